// ==== src/eebl_top.sv ====
// Two-level event and breakpoint logic watching target fetches and data cycles
`timescale 1ns/1ps
module eebl_top #(
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    // Target instruction fetch
    input  wire logic                                   fetch_valid,
    input  wire logic [ADDR_W-1:0]                      fetch_addr,
    // Target data cycle
    input  wire logic                                   data_valid,
    input  wire logic                                   data_write,
    input  wire logic [ADDR_W-1:0]                      data_addr,
    input  wire logic [eebl_pkg::DATA_W-1:0]            data_wdata,
    input  wire logic [15:0]                            cpu_status_word,
    // Fetch comparators [level][comparator]
    input  wire logic [1:0][1:0]                        ia_en,
    input  wire logic [1:0][1:0][ADDR_W-1:0]            ia_addr,
    input  wire logic [1:0][1:0][eebl_pkg::RANGE_W-1:0] ia_mask,
    // Data comparators [level][comparator]
    input  wire logic [1:0][1:0]                        da_en,
    input  wire logic [1:0][1:0]                        da_on_read,
    input  wire logic [1:0][1:0]                        da_on_write,
    input  wire logic [1:0][1:0][ADDR_W-1:0]            da_addr,
    input  wire logic [1:0][1:0][eebl_pkg::RANGE_W-1:0] da_mask,
    input  wire logic [1:0][1:0]                        dv_en,
    input  wire logic [1:0][1:0]                        dv_or,
    input  wire logic [1:0][1:0][eebl_pkg::DATA_W-1:0]  dv_value,
    input  wire logic [1:0][1:0][1:0]                   dv_mask_sel,
    // Level actions
    input  wire logic [1:0]                             brk_before,
    input  wire logic [1:0]                             brk_now,
    input  wire logic [1:0]                             out_on,
    input  wire logic [1:0]                             out_off,
    input  wire logic [1:0][eebl_pkg::RPT_W-1:0]        rpt_count,
    input  wire logic [1:0][1:0]                        depend,
    input  wire logic [1:0]                             prio_en,
    input  wire logic [eebl_pkg::ILVL_W-1:0]            monitor_level,
    // Global control
    input  wire eebl_pkg::eebl_out_mode_e               out_mode,
    input  wire logic                                   in_latched,
    input  wire logic                                   rearm,
    // External trigger
    input  wire logic                                   event_in_pin,
    output      logic                                   event_out_pin,
    // Results
    output      logic                                   halt_before,
    output      logic                                   halt_now,
    output      logic [1:0]                             level_fire,
    output      logic                                   ext_in_level
);

    eebl_pkg::eebl_state_s st_q;
    eebl_pkg::eebl_state_s st_d;

    logic [1:0][1:0] ia_hit;
    logic [1:0][1:0] da_addr_hit;
    logic [1:0][1:0] da_hit;
    logic [1:0]      ia_any;
    logic [1:0]      cond;
    logic [1:0]      prio_ok;
    logic [1:0]      dep_ok;
    logic            ext_used;
    logic [1:0]      on_hit;
    logic [1:0]      off_hit;

    // Four address comparators per level
    for (genvar l = 0; l < eebl_pkg::LEVELS; l++) begin : g_lvl
        for (genvar k = 0; k < eebl_pkg::CMP_PER_LVL; k++) begin : g_cmp
            eebl_cmp #(.ADDR_W(ADDR_W)) u_ia (
                .en       (ia_en[l][k]),
                .valid    (fetch_valid),
                .addr     (fetch_addr),
                .ref_addr (ia_addr[l][k]),
                .mask     (ia_mask[l][k]),
                .hit      (ia_hit[l][k])
            );
            eebl_cmp #(.ADDR_W(ADDR_W)) u_da (
                .en       (da_en[l][k]),
                .valid    (data_valid && (data_write ? da_on_write[l][k]
                                                     : da_on_read[l][k])),
                .addr     (data_addr),
                .ref_addr (da_addr[l][k]),
                .mask     (da_mask[l][k]),
                .hit      (da_addr_hit[l][k])
            );
        end
    end

    assign ext_used = in_latched ? st_q.latched : st_q.sync2;

    always_comb begin
        logic [eebl_pkg::DATA_W-1:0] vmask;
        logic                        vhit;
        vmask = eebl_pkg::DV_MASK_WORD;
        vhit  = 1'b0;
        for (int l = 0; l < eebl_pkg::LEVELS; l++) begin
            for (int k = 0; k < eebl_pkg::CMP_PER_LVL; k++) begin
                case (dv_mask_sel[l][k])
                    eebl_pkg::DV_SEL_LOW:  vmask = eebl_pkg::DV_MASK_LOW;
                    eebl_pkg::DV_SEL_HIGH: vmask = eebl_pkg::DV_MASK_HIGH;
                    default:               vmask = eebl_pkg::DV_MASK_WORD;
                endcase
                // Value compare only means anything on a write
                vhit = data_valid && data_write && da_en[l][k]
                       && (((data_wdata ^ dv_value[l][k]) & vmask) == '0);
                if (!dv_en[l][k]) begin
                    da_hit[l][k] = da_addr_hit[l][k];
                end else if (dv_or[l][k]) begin
                    da_hit[l][k] = da_addr_hit[l][k] || vhit;
                end else begin
                    da_hit[l][k] = da_addr_hit[l][k] && vhit;
                end
            end
            ia_any[l] = |ia_hit[l];
            case (depend[l])
                eebl_pkg::DEP_EXT_IN: dep_ok[l] = ext_used;
                eebl_pkg::DEP_OTHER:  dep_ok[l] = st_q.fire[1-l];
                default:              dep_ok[l] = 1'b1;
            endcase
            cond[l]    = (ia_any[l] || (|da_hit[l])) && dep_ok[l];
            prio_ok[l] = !prio_en[l]
                         || (cpu_status_word[eebl_pkg::ILVL_LSB +: eebl_pkg::ILVL_W]
                             < monitor_level);
        end
    end

    always_comb begin
        logic [eebl_pkg::RPT_W-1:0] nxt;
        nxt  = eebl_pkg::CNT_RESET;
        st_d = st_q;
        st_d.sync1 = event_in_pin;
        st_d.sync2 = st_q.sync1;
        // Rearm clears; a fresh assertion in the same cycle still wins
        if (rearm) begin
            st_d.latched = 1'b0;
        end
        if (st_q.sync2) begin
            st_d.latched = 1'b1;
        end
        for (int l = 0; l < eebl_pkg::LEVELS; l++) begin
            nxt = st_q.cnt[l] + 16'h0001;
            st_d.fire[l] = 1'b0;
            if (rearm) begin
                st_d.cnt[l] = eebl_pkg::CNT_RESET;
            end else if (cond[l] && rpt_count[l] != '0) begin
                if (nxt >= rpt_count[l]) begin
                    st_d.fire[l] = 1'b1;
                    st_d.cnt[l]  = eebl_pkg::CNT_RESET;
                end else begin
                    st_d.cnt[l] = nxt;
                end
            end
            on_hit[l]  = st_d.fire[l] && out_on[l];
            off_hit[l] = st_d.fire[l] && out_off[l];
        end
        // Only a fetch match can stop before the instruction runs
        st_d.halt_before = |(st_d.fire & brk_before & ia_any & prio_ok);
        st_d.halt_now    = |(st_d.fire & brk_now & prio_ok);
        case (out_mode)
            eebl_pkg::EEBL_OUT_HOLD: begin
                if (|off_hit) begin
                    st_d.evout = 1'b0;
                end
                if (|on_hit) begin
                    st_d.evout = 1'b1;
                end
            end
            eebl_pkg::EEBL_OUT_FOLLOW: st_d.evout = |on_hit;
            default:                   st_d.evout = |st_d.fire;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign event_out_pin = st_q.evout;
    assign halt_before   = st_q.halt_before;
    assign halt_now      = st_q.halt_now;
    assign level_fire    = st_q.fire;
    assign ext_in_level  = st_q.sync2;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_sync_two_regs: assert property (
        ##2 ext_in_level == $past(event_in_pin, 2))
        else $error("external input not delayed by two registers");
    a_zero_never_fires: assert property (
        level_fire[0] |-> $past(rpt_count[0]) != '0)
        else $error("level fired with zero repeat count");
    a_fire_needs_cond: assert property (
        level_fire[1] |-> $past(cond[1]))
        else $error("level fired without its condition");
    a_before_fetch_only: assert property (
        halt_before |-> $past(|(ia_any & brk_before & st_d.fire)))
        else $error("halt before execute without fetch match");
    a_prio_gate_halt: assert property (
        halt_now |-> $past(|(st_d.fire & brk_now & (~prio_en
            | {2{cpu_status_word[eebl_pkg::ILVL_LSB +: eebl_pkg::ILVL_W] < monitor_level}}))))
        else $error("halt issued while priority blocks it");
    a_pulse_mode_out: assert property (
        (out_mode == eebl_pkg::EEBL_OUT_PULSE) |=> event_out_pin == |level_fire)
        else $error("pulse mode output disagrees with level events");
    a_hold_keeps_set: assert property (
        (out_mode == eebl_pkg::EEBL_OUT_HOLD && event_out_pin && !(|off_hit))
        |=> event_out_pin)
        else $error("hold mode output dropped without turn-off");
    a_follow_tracks_on: assert property (
        (out_mode == eebl_pkg::EEBL_OUT_FOLLOW) |=> event_out_pin == $past(|on_hit))
        else $error("follow mode output does not track turn-on event");
    a_latch_holds: assert property (
        (st_q.latched && !rearm) |=> st_q.latched)
        else $error("latched input lost before rearm");

    c_fetch_break: cover property (fetch_valid ##1 halt_before);
    c_data_break:  cover property (data_valid && data_write ##1 halt_now);
    c_hold_cycle:  cover property (out_mode == eebl_pkg::EEBL_OUT_HOLD && event_out_pin
                                   ##[1:20] !event_out_pin);
    c_depend_ext:  cover property (depend[0] == eebl_pkg::DEP_EXT_IN ##1 level_fire[0]);

endmodule : eebl_top

// ==== src/eebl_pkg.sv ====
// Constants and types shared by the emulator event and breakpoint logic
package eebl_pkg;

    // Geometry
    localparam int          LEVELS      = 2;
    localparam int          CMP_PER_LVL = 2;
    localparam int          RPT_W       = 16;
    localparam int          DATA_W      = 16;
    localparam int          RANGE_W     = 16;

    // Range mask reaches at most 64K
    localparam logic [RANGE_W-1:0] RANGE_LIMIT = 16'hFFFF;

    // Data value mask selections
    localparam logic [1:0]  DV_SEL_LOW  = 2'h0;
    localparam logic [1:0]  DV_SEL_HIGH = 2'h1;
    localparam logic [DATA_W-1:0] DV_MASK_LOW  = 16'h00FF;
    localparam logic [DATA_W-1:0] DV_MASK_HIGH = 16'hFF00;
    localparam logic [DATA_W-1:0] DV_MASK_WORD = 16'hFFFF;

    // Dependency selections
    localparam logic [1:0]  DEP_NONE    = 2'h0;
    localparam logic [1:0]  DEP_EXT_IN  = 2'h1;
    localparam logic [1:0]  DEP_OTHER   = 2'h2;

    // Interrupt level field of the cpu status word
    localparam int          ILVL_LSB    = 12;
    localparam int          ILVL_W      = 4;

    // Reset values
    localparam logic [RPT_W-1:0] CNT_RESET = 16'h0000;

    // Trigger output modes, one-hot so hold and follow cannot both be chosen
    typedef enum logic [2:0] {
        EEBL_OUT_PULSE  = 3'h1,
        EEBL_OUT_HOLD   = 3'h2,
        EEBL_OUT_FOLLOW = 3'h4
    } eebl_out_mode_e;

    typedef struct packed {
        logic                        sync1;
        logic                        sync2;
        logic                        latched;
        logic [LEVELS-1:0][RPT_W-1:0] cnt;
        logic [LEVELS-1:0]           fire;
        logic                        halt_before;
        logic                        halt_now;
        logic                        evout;
    } eebl_state_s;

endpackage : eebl_pkg

// ==== src/eebl_cmp.sv ====
// Address comparator with optional range mask
`timescale 1ns/1ps
module eebl_cmp #(
    parameter int ADDR_W = 24
) (
    // Qualification
    input  wire logic                           en,
    input  wire logic                           valid,
    // Compare
    input  wire logic [ADDR_W-1:0]              addr,
    input  wire logic [ADDR_W-1:0]              ref_addr,
    input  wire logic [eebl_pkg::RANGE_W-1:0]   mask,
    // Result
    output      logic                           hit
);

    logic [ADDR_W-1:0] care;

    // Mask bits above 64K are ignored, so the range cannot grow past it
    always_comb begin
        care = '1;
        care[eebl_pkg::RANGE_W-1:0] = ~(mask & eebl_pkg::RANGE_LIMIT);
        hit  = en && valid && (((addr ^ ref_addr) & care) == '0);
    end

endmodule : eebl_cmp

// ==== verification/eebl_target_model.sv ====
// Target processor bus and external trigger source model
`timescale 1ns/1ps
module eebl_target_model (
    // Clock
    input  wire logic        clock,
    // Target bus
    output      logic        fetch_valid,
    output      logic [23:0] fetch_addr,
    output      logic        data_valid,
    output      logic        data_write,
    output      logic [23:0] data_addr,
    output      logic [15:0] data_wdata,
    // Trigger equipment
    output      logic        event_in_pin
);
    initial begin
        {fetch_valid, data_valid, data_write, event_in_pin} = 4'h0;
        {fetch_addr, data_addr, data_wdata} = '0;
    end
    // One cycle per access; released lines show the inverse so stale values never match
    task automatic fetch(input logic [23:0] a);
        @(posedge clock);
        fetch_valid <= 1'b1;
        fetch_addr  <= a;
        @(posedge clock);
        fetch_valid <= 1'b0;
        fetch_addr  <= ~a;
    endtask : fetch
    task automatic dcyc(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge clock);
        data_valid <= 1'b1;
        data_write <= w;
        data_addr  <= a;
        data_wdata <= d;
        @(posedge clock);
        data_valid <= 1'b0;
        data_write <= ~w;
        data_addr  <= ~a;
        data_wdata <= ~d;
    endtask : dcyc
    task automatic trig(input logic v);
        @(posedge clock);
        event_in_pin <= v;
    endtask : trig
endmodule : eebl_target_model

// ==== verification/test_emulator_event_breakpoint_logic.sv ====
// Self-checking bench for the two-level event and breakpoint logic
`timescale 1ns/1ps
module test_emulator_event_breakpoint_logic;
    logic clock, rst, rearm, in_latched, event_in_pin, fetch_valid, data_valid, data_write;
    logic event_out_pin, halt_before, halt_now, ext_in_level;
    logic [23:0] fetch_addr, data_addr;
    logic [15:0] data_wdata, cpu_status_word;
    logic [3:0] monitor_level;
    logic [1:0] brk_before, brk_now, out_on, out_off, prio_en, level_fire;
    logic [1:0][15:0] rpt_count;
    logic [1:0][1:0] ia_en, da_en, da_on_read, da_on_write, dv_en, dv_or, depend;
    logic [1:0][1:0][23:0] ia_addr, da_addr;
    logic [1:0][1:0][15:0] ia_mask, da_mask, dv_value;
    logic [1:0][1:0][1:0] dv_mask_sel;
    eebl_pkg::eebl_out_mode_e out_mode;
    int errors, comparisons;
    wire [4:0] obs = {level_fire, halt_before, halt_now, event_out_pin};

    eebl_top dut (.clock, .rst, .fetch_valid, .fetch_addr, .data_valid, .data_write, .data_addr,
        .data_wdata, .cpu_status_word, .ia_en, .ia_addr, .ia_mask, .da_en, .da_on_read,
        .da_on_write, .da_addr, .da_mask, .dv_en, .dv_or, .dv_value, .dv_mask_sel, .brk_before,
        .brk_now, .out_on, .out_off, .rpt_count, .depend, .prio_en, .monitor_level, .out_mode,
        .in_latched, .rearm, .event_in_pin, .event_out_pin, .halt_before, .halt_now,
        .level_fire, .ext_in_level);
    eebl_target_model tgt (.clock, .fetch_valid, .fetch_addr, .data_valid, .data_write,
        .data_addr, .data_wdata, .event_in_pin);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Outputs are looked at 1 ns after the sampling edge, where they stand
    task automatic fx(input logic [23:0] a, input logic [4:0] e);
        tgt.fetch(a);
        #1;
        chk("fetch outputs", e, obs);
    endtask : fx
    task automatic dx(input logic w, input logic [23:0] a, input logic [15:0] d,
                      input logic [4:0] e, input logic [4:0] m);
        tgt.dcyc(w, a, d);
        #1;
        chk("data outputs", e, obs & m);
    endtask : dx
    task automatic idle(input int n, input logic [4:0] e);
        repeat (n) @(posedge clock);
        #1;
        chk("idle outputs", e, obs);
    endtask : idle
    task automatic rearm_pulse;
        @(posedge clock);
        rearm <= 1'b1;
        @(posedge clock);
        rearm <= 1'b0;
    endtask : rearm_pulse

    initial begin
        repeat (4000) @(posedge clock);
        errors++;
        $display("unexpected timeout expected finish seen hang");
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {rearm, in_latched, cpu_status_word, monitor_level} = '0;
        {brk_before, brk_now, out_on, out_off, prio_en, rpt_count} = '0;
        {ia_en, da_en, da_on_read, da_on_write, dv_en, dv_or, depend} = '0;
        {ia_addr, da_addr, ia_mask, da_mask, dv_value, dv_mask_sel} = '0;
        out_mode = eebl_pkg::EEBL_OUT_PULSE;
        errors = 0;
        comparisons = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        ia_en[0] <= 2'h3;
        ia_addr[0] <= {24'h005600, 24'h001234};
        ia_mask[0][1] <= 16'h00FF;
        rpt_count[0] <= 16'h0001;
        brk_before[0] <= 1'b1;
        fx(24'h001234, 5'h0D);
        idle(1, 5'h00);
        fx(24'h0056AB, 5'h0D);
        fx(24'h0057AB, 5'h00);
        fx(24'h015600, 5'h00);
        rpt_count[0] <= 16'h0003;
        fx(24'h001234, 5'h00);
        fx(24'h0056FF, 5'h00);
        fx(24'h001234, 5'h0D);
        rpt_count[0] <= 16'h0000;
        fx(24'h001234, 5'h00);
        $display("test fetch finished");
        ia_en <= '0;
        {rpt_count[1], brk_before[1], brk_now[1]} <= {16'h0001, 2'h3};
        {da_en[1][0], da_on_write[1][0], da_addr[1][0]} <= {2'h3, 24'h00ABCD};
        dx(1'b1, 24'h00ABCD, 16'h1234, 5'h13, 5'h1F);
        dx(1'b0, 24'h00ABCD, 16'h1234, 5'h00, 5'h1F);
        // Read qualifier and a small address range on the same comparator
        {da_on_read[1][0], da_mask[1][0]} <= {1'b1, 16'h000F};
        dx(1'b0, 24'h00ABC3, 16'h1234, 5'h13, 5'h1F);
        dx(1'b0, 24'h00AB3D, 16'h1234, 5'h00, 5'h1F);
        {da_on_read[1][0], da_mask[1][0]} <= '0;
        {dv_en[1][0], dv_value[1][0]} <= {1'b1, 16'h77FF};
        dx(1'b1, 24'h00ABCD, 16'h12FF, 5'h13, 5'h1F);
        dx(1'b1, 24'h00ABCD, 16'h12FE, 5'h00, 5'h1F);
        dv_mask_sel[1][0] <= eebl_pkg::DV_SEL_HIGH;
        dx(1'b1, 24'h00ABCD, 16'h7700, 5'h13, 5'h1F);
        dx(1'b1, 24'h00ABCD, 16'h7600, 5'h00, 5'h1F);
        dv_mask_sel[1][0] <= 2'h2;
        dx(1'b1, 24'h00ABCD, 16'h77FF, 5'h13, 5'h1F);
        dx(1'b1, 24'h00ABCD, 16'h76FF, 5'h00, 5'h1F);
        dv_or[1][0] <= 1'b1;
        dx(1'b1, 24'h00ABCE, 16'h77FF, 5'h13, 5'h1F);
        dx(1'b0, 24'h00ABCE, 16'h77FF, 5'h00, 5'h1F);
        {prio_en[1], monitor_level, cpu_status_word} <= {1'b1, 4'h4, 16'h5000};
        dx(1'b1, 24'h00ABCD, 16'h0000, 5'h00, 5'h06);
        cpu_status_word <= 16'h4000;
        dx(1'b1, 24'h00ABCD, 16'h0000, 5'h00, 5'h06);
        cpu_status_word <= 16'h3000;
        dx(1'b1, 24'h00ABCD, 16'h0000, 5'h02, 5'h06);
        $display("test data finished");
        {da_en, ia_en[0][0], rpt_count[0], depend[0]} <= {4'h0, 1'b1, 16'h0001, 2'h1};
        tgt.trig(1'b1);
        idle(1, 5'h00);
        chk("sync stage", 5'h00, {4'h0, ext_in_level});
        idle(1, 5'h00);
        chk("sync stage", 5'h01, {4'h0, ext_in_level});
        in_latched <= 1'b1;
        tgt.trig(1'b0);
        idle(3, 5'h00);
        rearm_pulse();
        fx(24'h001234, 5'h00);
        tgt.trig(1'b1);
        tgt.trig(1'b0);
        idle(3, 5'h00);
        fx(24'h001234, 5'h0D);
        fx(24'h001234, 5'h0D);
        rearm_pulse();
        fx(24'h001234, 5'h00);
        in_latched <= 1'b0;
        tgt.trig(1'b1);
        idle(3, 5'h00);
        fx(24'h001234, 5'h0D);
        tgt.trig(1'b0);
        idle(3, 5'h00);
        fx(24'h001234, 5'h00);
        $display("test trigger input finished");
        {depend, out_on[0], out_off[1], ia_en[1][0]} <= {4'h0, 3'h7};
        {ia_addr[1][0], rpt_count[1]} <= {24'h002000, 16'h0001};
        out_mode <= eebl_pkg::EEBL_OUT_HOLD;
        fx(24'h001234, 5'h0D);
        idle(2, 5'h01);
        // Level 1 still has both halts armed and passes the priority gate
        fx(24'h002000, 5'h16);
        idle(1, 5'h00);
        out_mode <= eebl_pkg::EEBL_OUT_FOLLOW;
        fx(24'h001234, 5'h0D);
        idle(1, 5'h00);
        out_on[0] <= 1'b0;
        fx(24'h001234, 5'h0C);
        out_mode <= eebl_pkg::EEBL_OUT_PULSE;
        fx(24'h002000, 5'h17);
        ia_addr[1][0] <= 24'h001234;
        fx(24'h001234, 5'h1F);
        $display("test output modes finished");
        // Level 1 waits for level 0's event of the cycle before
        depend[1] <= eebl_pkg::DEP_OTHER;
        da_en[1][0] <= 1'b1;
        dx(1'b1, 24'h00ABCD, 16'h0000, 5'h00, 5'h1F);
        fork
            tgt.fetch(24'h001234);
            begin
                @(posedge clock);
                dx(1'b1, 24'h00ABCD, 16'h0000, 5'h13, 5'h1F);
            end
        join
        $display("test dependency finished");
        wrap_up();
    end
endmodule : test_emulator_event_breakpoint_logic
